// *** hw/lse_ctrl.sv ***
// control and status registers of the three-engine led sequencer
`timescale 1ns/1ns
`include "lse_regs.svh"

// Behaviour
// (RL1) chip-on bit starts up or enters standby
// (RL2) standby blocks ctrl0 low bits, pwm, pointers
// (RL3) hold stops engine; pointer access only here
// (RL4) step executes, increments, returns to hold
// (RL5) free run executes continuously from pointer
// (RL6) execute once runs without incrementing, holds
// (RL7) run-style fields at ctrl0 5:4, 3:2, 1:0
// (RL8) program writes only in load, not busy
// (RL9) host polls busy or waits 1 ms
// (RL10) any load holds all engines, freezes pwm
// (RL11) entering load zeroes that engine's pointer
// (RL12) host enters load only from disabled
// (RL13) running pointer wraps to zero at limit
// (RL14) halt aborts instruction and stops engine
// (RL15) op-state codes disabled, load, run, halt
// (RL16) engine three op-state at ctrl1 bits 1:0
// (RL17) per-output proportional dimming enable bits
// (RL18) proportional outputs scale by same ratio
// (RL19) read-only engine to output mapping registers
// (RL20) gain bits 7:6 threshold, bit 5 adaptive
// (RL21) gain bits 4:3 select hold interval
// (RL22) gain bit 2 enables unity return timer
// (RL23) pointers are seven bits, zero to 95
// (RL24) engines timed by internal or external clock
module lse_ctrl #(
	parameter int LOAD_INIT_CYC = `LSE_LOAD_INIT_CYC,
	parameter int STARTUP_CYC = `LSE_STARTUP_CYC
) (
	// clock and reset
	input wire logic mclk,
	input wire logic rst_n,
	// register access from the serial slave
	input lse_pkg::lse_bus_s bus,
	output logic [7:0] rdata,
	// engine timing
	input wire logic ext_clk_sel,
	input wire logic ext_clk_tick,
	// engine mapping from the instruction unit, bit 8 is output nine
	input wire logic [2:0][8:0] eng_map,
	// power state
	output logic chip_normal,
	output logic chip_standby,
	// engine control
	output logic [2:0] exec_pulse,
	output logic [2:0] abort_pulse,
	output logic [2:0][6:0] seq_pointer,
	output logic [2:0] engine_busy,
	output logic [2:0] prog_wr_allow,
	output logic pwm_frozen,
	output logic pwm_wr_allow,
	// output and pump settings
	output logic [8:0] proportional_dim,
	output lse_pkg::lse_gain_s gain_setup
);

	localparam int ENG_DIV = `LSE_ENG_DIV;

	// busy and start-up counters are 20 bits wide
	if (LOAD_INIT_CYC < 1 || LOAD_INIT_CYC >= (1 << 20)) begin : load_cyc_bad
		$error("LOAD_INIT_CYC out of range");
	end
	if (STARTUP_CYC < 1 || STARTUP_CYC >= (1 << 20)) begin : startup_cyc_bad
		$error("STARTUP_CYC out of range");
	end

	lse_pkg::lse_state_s st_reg;
	lse_pkg::lse_state_s st_next;
	logic any_load;
	logic tick;
	logic in_standby;

	function automatic lse_pkg::lse_ptr_t ptr_inc(input lse_pkg::lse_ptr_t p);
		// (RL13) wrap at limit
		ptr_inc = (p == `LSE_PTR_MAX) ? 7'h00 : p + 7'h01;
	endfunction

	always_comb begin
		// (RL10) any load holds all engines and freezes pwm
		any_load = 1'b0;
		for (int i = 0; i < 3; i++) begin
			// (RL15) op-state decode
			if (st_reg.ctrl1[4 - 2 * i +: 2] == `LSE_OP_LOAD)
				any_load = 1'b1;
		end
	end

	assign in_standby = (st_reg.pwr != lse_pkg::LSE_NORMAL);
	// (RL24) engine clock choice
	assign tick = (st_reg.pwr == lse_pkg::LSE_NORMAL) &&
		(ext_clk_sel ? ext_clk_tick : (st_reg.div == 12'(ENG_DIV - 1)));

	always_comb begin
		logic [1:0] op;
		logic [1:0] sty;
		logic [1:0] sel;
		op = 2'h0;
		sty = 2'h0;
		sel = 2'h0;
		st_next = st_reg;
		st_next.exec = 3'h0;
		st_next.abort = 3'h0;
		st_next.div = (st_reg.div == 12'(ENG_DIV - 1)) ? 12'h000 : st_reg.div + 12'h001;
		// (RL1) power sequencing
		unique case (st_reg.pwr)
			lse_pkg::LSE_STANDBY: begin
				if (st_reg.ctrl0[`LSE_BIT_CHIP_ON]) begin
					st_next.pwr = lse_pkg::LSE_STARTUP;
					st_next.up_cnt = '0;
				end
			end
			lse_pkg::LSE_STARTUP: begin
				st_next.up_cnt = st_reg.up_cnt + 20'h00001;
				if (!st_reg.ctrl0[`LSE_BIT_CHIP_ON])
					st_next.pwr = lse_pkg::LSE_STANDBY;
				else if (st_reg.up_cnt == 20'(STARTUP_CYC - 1))
					st_next.pwr = lse_pkg::LSE_NORMAL;
			end
			lse_pkg::LSE_NORMAL: begin
				if (!st_reg.ctrl0[`LSE_BIT_CHIP_ON])
					st_next.pwr = lse_pkg::LSE_STANDBY;
			end
		endcase
		// busy count shared: a new load restarts it for all
		if (|st_reg.busy) begin
			st_next.busy_cnt = st_reg.busy_cnt + 20'h00001;
			if (st_reg.busy_cnt == 20'(LOAD_INIT_CYC - 1))
				st_next.busy = 3'h0;
		end
		for (int i = 0; i < 3; i++) begin
			// (RL7) style field position
			sty = st_reg.ctrl0[4 - 2 * i +: 2];
			// (RL16) engine three at ctrl1 1:0
			op = st_reg.ctrl1[4 - 2 * i +: 2];
			st_next.prev_op[i] = op;
			if (op != `LSE_OP_LOAD)
				st_next.busy[i] = 1'b0;
			// (RL11) load entry zeroes pointer
			if (op == `LSE_OP_LOAD && st_reg.prev_op[i] != `LSE_OP_LOAD) begin
				st_next.ptr[i] = 7'h00;
				st_next.busy[i] = 1'b1;
				st_next.busy_cnt = '0;
			end
			// (RL14) halt aborts at once
			if (op == `LSE_OP_HALT && st_reg.prev_op[i] != `LSE_OP_HALT)
				st_next.abort[i] = 1'b1;
			if (op == `LSE_OP_RUN && tick && !any_load) begin
				unique case (sty)
					// (RL3) hold does nothing
					`LSE_STY_HOLD: begin
					end
					// (RL4) single step
					`LSE_STY_STEP: begin
						st_next.exec[i] = 1'b1;
						st_next.ptr[i] = ptr_inc(st_reg.ptr[i]);
						st_next.ctrl0[4 - 2 * i +: 2] = `LSE_STY_HOLD;
					end
					// (RL5) free run
					`LSE_STY_FREE: begin
						st_next.exec[i] = 1'b1;
						st_next.ptr[i] = ptr_inc(st_reg.ptr[i]);
					end
					// (RL6) execute once
					`LSE_STY_ONCE: begin
						st_next.exec[i] = 1'b1;
						st_next.ctrl0[4 - 2 * i +: 2] = `LSE_STY_HOLD;
					end
				endcase
			end
		end
		// host writes land after engine updates, so a write wins
		if (bus.wr) begin
			case (bus.addr)
				`LSE_OFS_CTRL0: begin
					// (RL2) standby keeps low bits
					if (in_standby)
						st_next.ctrl0 = {bus.wdata[7:6], st_next.ctrl0[5:0]};
					else
						st_next.ctrl0 = bus.wdata;
				end
				`LSE_OFS_CTRL1: st_next.ctrl1 = bus.wdata;
				`LSE_OFS_DIMH: st_next.dimh = {7'h00, bus.wdata[0]};
				`LSE_OFS_DIML: st_next.diml = bus.wdata;
				`LSE_OFS_GAIN: st_next.gain = bus.wdata & `LSE_GAIN_MASK;
				`LSE_OFS_PTR1, `LSE_OFS_PTR2, `LSE_OFS_PTR3: begin
					sel = bus.addr[1:0] - 2'h3;
					sty = st_reg.ctrl0[4 - 2 * sel +: 2];
					// (RL23) only values up to limit
					if (!in_standby && sty == `LSE_STY_HOLD &&
						bus.wdata[6:0] <= `LSE_PTR_MAX)
						st_next.ptr[sel] = bus.wdata[6:0];
				end
				default: begin
				end
			endcase
		end
		if (bus.rd) begin
			case (bus.addr)
				`LSE_OFS_CTRL0: st_next.rdata = st_reg.ctrl0;
				`LSE_OFS_CTRL1: st_next.rdata = st_reg.ctrl1;
				`LSE_OFS_DIMH: st_next.rdata = st_reg.dimh;
				`LSE_OFS_DIML: st_next.rdata = st_reg.diml;
				`LSE_OFS_GAIN: st_next.rdata = st_reg.gain;
				// (RL19) mapping read-only
				`LSE_OFS_MAP1H: st_next.rdata = {7'h00, eng_map[0][8]};
				`LSE_OFS_MAP1L: st_next.rdata = eng_map[0][7:0];
				`LSE_OFS_MAP2H: st_next.rdata = {7'h00, eng_map[1][8]};
				`LSE_OFS_MAP2L: st_next.rdata = eng_map[1][7:0];
				`LSE_OFS_MAP3H: st_next.rdata = {7'h00, eng_map[2][8]};
				`LSE_OFS_MAP3L: st_next.rdata = eng_map[2][7:0];
				`LSE_OFS_PTR1, `LSE_OFS_PTR2, `LSE_OFS_PTR3: begin
					sel = bus.addr[1:0] - 2'h3;
					// (RL3) pointer visible only in hold
					if (!in_standby && st_reg.ctrl0[4 - 2 * sel +: 2] == `LSE_STY_HOLD)
						st_next.rdata = {1'b0, st_reg.ptr[sel]};
					else
						st_next.rdata = 8'h00;
				end
				default: st_next.rdata = 8'h00;
			endcase
		end
	end

	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			st_reg <= '0;
		end else begin
			st_reg <= st_next;
		end
	end

	assign rdata = st_reg.rdata;
	assign chip_normal = (st_reg.pwr == lse_pkg::LSE_NORMAL);
	assign chip_standby = (st_reg.pwr == lse_pkg::LSE_STANDBY);
	assign exec_pulse = st_reg.exec;
	assign abort_pulse = st_reg.abort;
	assign seq_pointer = st_reg.ptr;
	assign engine_busy = st_reg.busy;
	assign pwm_frozen = any_load;
	// (RL2) no pwm writes while not normal
	assign pwm_wr_allow = !in_standby && !any_load;
	// (RL17) enable bits, nine is high
	// (RL18) scaling done in the pwm path
	assign proportional_dim = {st_reg.dimh[0], st_reg.diml};
	// (RL20) threshold and adaptive level
	// (RL21) hold interval field
	// (RL22) unity return timer bit
	assign gain_setup = st_reg.gain[7:2];

	always_comb begin
		for (int i = 0; i < 3; i++) begin
			// (RL8) memory write gate
			// busy lands a cycle after entry, so the entry cycle is blocked too
			prog_wr_allow[i] = (st_reg.ctrl1[4 - 2 * i +: 2] == `LSE_OP_LOAD) &&
				(st_reg.prev_op[i] == `LSE_OP_LOAD) && !st_reg.busy[i];
		end
	end

	sequence step_req(int e);
		st_reg.ctrl1[4 - 2 * e +: 2] == `LSE_OP_RUN && !any_load && tick &&
			st_reg.ctrl0[4 - 2 * e +: 2] == `LSE_STY_STEP && !bus.wr;
	endsequence

	sequence back_to_hold(int e);
		st_reg.ctrl0[4 - 2 * e +: 2] == `LSE_STY_HOLD && st_reg.exec[e];
	endsequence

	step_hold_a: assert property (@(posedge mclk) disable iff (!rst_n) // RL4
		step_req(0) |=> back_to_hold(0) and
			(st_reg.ptr[0] == ($past(st_reg.ptr[0]) == 7'h5f ? 7'h00 : $past(st_reg.ptr[0]) + 7'h01)))
		else $error("step did not advance and hold");

	once_keep_a: assert property (@(posedge mclk) disable iff (!rst_n) // RL6
		(st_reg.ctrl1[3:2] == `LSE_OP_RUN && !any_load && tick && !bus.wr &&
			st_reg.ctrl0[3:2] == `LSE_STY_ONCE) |=>
		(st_reg.exec[1] && st_reg.ptr[1] == $past(st_reg.ptr[1]) && st_reg.ctrl0[3:2] == 2'h0))
		else $error("execute once changed pointer");

	load_freeze_a: assert property (@(posedge mclk) disable iff (!rst_n) // RL10
		any_load |-> (pwm_frozen && !pwm_wr_allow) ##1 (exec_pulse == 3'h0))
		else $error("engine ran during load");

	load_ptr_a: assert property (@(posedge mclk) disable iff (!rst_n) // RL11
		(st_reg.ctrl1[3:2] == `LSE_OP_LOAD && st_reg.prev_op[1] == `LSE_OP_DIS &&
			!bus.wr) |=> (st_reg.ptr[1] == 7'h00 && st_reg.busy[1]))
		else $error("load did not zero pointer");

	prog_gate_a: assert property (@(posedge mclk) disable iff (!rst_n) // RL8
		$rose(prog_wr_allow[1]) |-> (st_reg.ctrl1[3:2] == `LSE_OP_LOAD && $past(engine_busy[1])))
		else $error("program write allowed wrongly");

	busy_len_a: assert property (@(posedge mclk) disable iff (!rst_n) // RL8
		($fell(engine_busy[1]) && $past(st_reg.ctrl1[3:2]) == `LSE_OP_LOAD) |->
			$past(st_reg.busy_cnt) == 20'(LOAD_INIT_CYC - 1))
		else $error("busy ended before load time");

	halt_abort_a: assert property (@(posedge mclk) disable iff (!rst_n) // RL14
		(st_reg.ctrl1[1:0] == `LSE_OP_HALT && st_reg.prev_op[2] == `LSE_OP_RUN) |=>
		(abort_pulse[2] ##1 (!abort_pulse[2] && !exec_pulse[2])))
		else $error("halt did not abort");

	halt_still_a: assert property (@(posedge mclk) disable iff (!rst_n) // RL14
		st_reg.ctrl1[1:0] == `LSE_OP_HALT |=> !exec_pulse[2])
		else $error("halted engine executed");

	ptr_lock_a: assert property (@(posedge mclk) disable iff (!rst_n) // RL3
		(bus.wr && bus.addr == `LSE_OFS_PTR1 && !tick &&
			st_reg.ctrl1[5:4] != `LSE_OP_LOAD &&
			(in_standby || st_reg.ctrl0[5:4] != `LSE_STY_HOLD)) |=> $stable(st_reg.ptr[0]))
		else $error("pointer written outside hold");

	standby_pwm_a: assert property (@(posedge mclk) disable iff (!rst_n) // RL2
		in_standby |-> !pwm_wr_allow)
		else $error("pwm writable in standby");

	standby_lock_a: assert property (@(posedge mclk) disable iff (!rst_n) // RL2
		(in_standby && bus.wr && bus.addr == `LSE_OFS_CTRL0) |=>
		st_reg.ctrl0[5:0] == $past(st_reg.ctrl0[5:0]))
		else $error("standby let low bits change");

	power_up_a: assert property (@(posedge mclk) disable iff (!rst_n) // RL1
		(chip_standby && st_reg.ctrl0[6]) |=> st_reg.pwr == lse_pkg::LSE_STARTUP)
		else $error("chip on did not start up");

	power_off_a: assert property (@(posedge mclk) disable iff (!rst_n) // RL1
		(chip_normal && !st_reg.ctrl0[`LSE_BIT_CHIP_ON]) |=> chip_standby)
		else $error("chip off did not enter standby");

	wrap_a: assert property (@(posedge mclk) disable iff (!rst_n) // RL13
		(st_reg.ptr[2] == 7'h5f && exec_pulse[2] == 1'b0 && st_reg.ctrl1[1:0] == 2'h2 &&
			st_reg.ctrl0[1:0] == 2'h2 && tick && !any_load && !bus.wr) |=> st_reg.ptr[2] == 7'h00)
		else $error("pointer did not wrap");

	ptr_range_a: assert property (@(posedge mclk) disable iff (!rst_n) // RL23
		st_reg.ptr[0] <= 7'h5f && st_reg.ptr[1] <= 7'h5f && st_reg.ptr[2] <= 7'h5f)
		else $error("pointer above limit");

endmodule

// *** hw/lse_regs.svh ***
// register offsets, field positions, reset values and timing counts
`ifndef LSE_REGS_SVH
`define LSE_REGS_SVH
`define LSE_OFS_CTRL0 8'h00
`define LSE_OFS_CTRL1 8'h01
`define LSE_OFS_DIMH 8'h02
`define LSE_OFS_DIML 8'h03
`define LSE_OFS_PTR1 8'h37
`define LSE_OFS_PTR2 8'h38
`define LSE_OFS_PTR3 8'h39
`define LSE_OFS_MAP1H 8'h70
`define LSE_OFS_MAP1L 8'h71
`define LSE_OFS_MAP2H 8'h72
`define LSE_OFS_MAP2L 8'h73
`define LSE_OFS_MAP3H 8'h74
`define LSE_OFS_MAP3L 8'h75
`define LSE_OFS_GAIN 8'h76
`define LSE_RST_BYTE 8'h00
`define LSE_BIT_CHIP_ON 6
`define LSE_GAIN_MASK 8'hfc
`define LSE_STY_HOLD 2'h0
`define LSE_STY_STEP 2'h1
`define LSE_STY_FREE 2'h2
`define LSE_STY_ONCE 2'h3
`define LSE_OP_DIS 2'h0
`define LSE_OP_LOAD 2'h1
`define LSE_OP_RUN 2'h2
`define LSE_OP_HALT 2'h3
`define LSE_PTR_MAX 7'h5f
`define LSE_MCLK_HZ 100000000
`define LSE_ENG_CLK_HZ 32700
`define LSE_ENG_DIV (`LSE_MCLK_HZ / `LSE_ENG_CLK_HZ)
`define LSE_LOAD_INIT_US 1000
`define LSE_LOAD_INIT_CYC (`LSE_LOAD_INIT_US * (`LSE_MCLK_HZ / 1000000))
`define LSE_STARTUP_US 500
`define LSE_STARTUP_CYC (`LSE_STARTUP_US * (`LSE_MCLK_HZ / 1000000))
`endif

// *** hw/lse_pkg.sv ***
// types shared by the sequencer control block
package lse_pkg;
	typedef logic [19:0] lse_cnt_t;
	typedef logic [6:0] lse_ptr_t;
	typedef enum logic [1:0] {
		LSE_STANDBY,
		LSE_STARTUP,
		LSE_NORMAL
	} lse_pwr_e;
	typedef struct packed {
		logic wr;
		logic rd;
		logic [7:0] addr;
		logic [7:0] wdata;
	} lse_bus_s;
	typedef struct packed {
		logic [1:0] threshold;
		logic adaptive_level_on;
		logic [1:0] hold_interval;
		logic unity_return_timer_on;
	} lse_gain_s;
	typedef struct packed {
		lse_pwr_e pwr;
		logic [7:0] ctrl0;
		logic [7:0] ctrl1;
		logic [7:0] dimh;
		logic [7:0] diml;
		logic [7:0] gain;
		logic [2:0][6:0] ptr;
		logic [2:0][1:0] prev_op;
		logic [2:0] exec;
		logic [2:0] abort;
		logic [2:0] busy;
		lse_cnt_t busy_cnt;
		lse_cnt_t up_cnt;
		logic [11:0] div;
		logic [7:0] rdata;
	} lse_state_s;
endpackage

// *** verification/lse_host.sv ***
// host model issuing single byte register accesses
`timescale 1ns/1ns
module lse_host (
	// clock
	input wire logic mclk,
	// register access
	output lse_pkg::lse_bus_s bus,
	input wire logic [7:0] rdata
);
	initial bus = '0;
	// released lines show inverted values so stale data cannot pass
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge mclk);
		bus <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
		@(posedge mclk);
		bus <= '{wr: 1'b0, rd: 1'b0, addr: ~a, wdata: ~d};
	endtask
	task automatic rd(input logic [7:0] a, output logic [7:0] d);
		@(posedge mclk);
		bus <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
		@(posedge mclk);
		bus <= '{wr: 1'b0, rd: 1'b0, addr: ~a, wdata: 8'hff};
		@(posedge mclk);
		d = rdata;
	endtask
endmodule

// *** verification/tb_lse_ctrl.sv ***
// self-checking bench for the sequencer control registers
`timescale 1ns/1ns
module tb_lse_ctrl;
	logic mclk = 1'b0;
	logic rst_n = 1'b0;
	lse_pkg::lse_bus_s bus;
	logic [7:0] rdata;
	logic ext_clk_sel = 1'b1;
	logic ext_clk_tick = 1'b0;
	logic [2:0][8:0] eng_map = {9'h1ff, 9'h0c3, 9'h15a};
	logic chip_normal, chip_standby, pwm_frozen, pwm_wr_allow;
	logic [2:0] exec_pulse, abort_pulse, engine_busy, prog_wr_allow;
	logic [2:0][6:0] seq_pointer;
	logic [8:0] proportional_dim;
	lse_pkg::lse_gain_s gain_setup;
	int err_count = 0;
	int num_checks = 0;
	int exec_cnt [3] = '{0, 0, 0};
	int abort_cnt = 0;
	int n;
	logic [7:0] map_exp [6] = '{8'h01, 8'h5a, 8'h00, 8'hc3, 8'h01, 8'hff};
	always #5 mclk = ~mclk;
	// short counts keep load and start-up waits brief
	lse_ctrl #(.LOAD_INIT_CYC(20), .STARTUP_CYC(10)) dut (.mclk(mclk), .rst_n(rst_n),
		.bus(bus), .rdata(rdata), .ext_clk_sel(ext_clk_sel), .ext_clk_tick(ext_clk_tick),
		.eng_map(eng_map), .chip_normal(chip_normal), .chip_standby(chip_standby),
		.exec_pulse(exec_pulse), .abort_pulse(abort_pulse), .seq_pointer(seq_pointer),
		.engine_busy(engine_busy), .prog_wr_allow(prog_wr_allow), .pwm_frozen(pwm_frozen),
		.pwm_wr_allow(pwm_wr_allow), .proportional_dim(proportional_dim),
		.gain_setup(gain_setup));
	lse_host host (.mclk(mclk), .bus(bus), .rdata(rdata));
	always @(posedge mclk) begin
		for (int i = 0; i < 3; i++) begin
			if (exec_pulse[i] === 1'b1) begin
				exec_cnt[i]++;
			end
		end
		if (abort_pulse[2] === 1'b1) begin
			abort_cnt++;
		end
	end
	task automatic chk(input logic [8:0] got, input logic [8:0] exp);
		num_checks++;
		if (got !== exp) begin
			err_count++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic rchk(input logic [7:0] a, input logic [7:0] exp);
		logic [7:0] d;
		host.rd(a, d);
		chk({1'b0, d}, {1'b0, exp});
	endtask
	task automatic tick(input int k);
		repeat (k) begin
			@(posedge mclk);
			ext_clk_tick <= 1'b1;
			@(posedge mclk);
			ext_clk_tick <= 1'b0;
			repeat (3) @(posedge mclk);
		end
	endtask
	task automatic complete_run;
		$display("checks %0d mismatches %0d", num_checks, err_count);
		if (err_count == 0 && num_checks > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask
	initial begin
		repeat (8) @(posedge mclk);
		rst_n <= 1'b1;
		for (int i = 0; i < 6; i++) begin
			rchk(8'h70 + 8'(i), map_exp[i]);
		end
		host.wr(8'h71, 8'h00);
		rchk(8'h71, 8'h5a);
		rchk(8'h01, 8'h00);
		rchk(8'h80, 8'h00);
		$display("test reset done");
		host.wr(8'h00, 8'h3f);
		rchk(8'h00, 8'h00);
		host.wr(8'h37, 8'h12);
		rchk(8'h37, 8'h00);
		host.wr(8'h02, 8'hff);
		host.wr(8'h03, 8'ha5);
		rchk(8'h02, 8'h01);
		chk(proportional_dim, 9'h1a5);
		host.wr(8'h76, 8'hb4);
		rchk(8'h76, 8'hb4);
		chk({3'h0, gain_setup}, 9'h02d);
		chk({8'h0, chip_standby}, 9'h001);
		$display("test standby done");
		host.wr(8'h00, 8'h40);
		n = 0;
		while (chip_normal !== 1'b1 && n < 50) begin
			@(posedge mclk);
			n++;
		end
		chk({8'h0, chip_normal}, 9'h001);
		host.wr(8'h37, 8'h5f);
		rchk(8'h37, 8'h5f);
		host.wr(8'h37, 8'h60);
		rchk(8'h37, 8'h5f);
		host.wr(8'h01, 8'h20);
		host.wr(8'h00, 8'h50);
		tick(1);
		chk({2'h0, seq_pointer[0]}, 9'h000);
		chk(9'(exec_cnt[0]), 9'h001);
		rchk(8'h00, 8'h40);
		host.wr(8'h38, 8'h05);
		host.wr(8'h01, 8'h28);
		host.wr(8'h00, 8'h4c);
		tick(1);
		chk({2'h0, seq_pointer[1]}, 9'h005);
		chk(9'(exec_cnt[1]), 9'h001);
		rchk(8'h00, 8'h40);
		host.wr(8'h39, 8'h5f);
		host.wr(8'h01, 8'h2a);
		host.wr(8'h00, 8'h42);
		tick(2);
		chk({2'h0, seq_pointer[2]}, 9'h001);
		rchk(8'h39, 8'h00);
		host.wr(8'h01, 8'h2b);
		tick(1);
		chk(9'(abort_cnt), 9'h001);
		chk(9'(exec_cnt[2]), 9'h002);
		$display("test styles done");
		host.wr(8'h01, 8'h23);
		host.wr(8'h00, 8'h60);
		host.wr(8'h01, 8'h27);
		#1;
		chk({8'h0, prog_wr_allow[1]}, 9'h000);
		@(posedge mclk);
		#1;
		chk({2'h0, seq_pointer[1]}, 9'h000);
		chk({6'h0, engine_busy[1], prog_wr_allow[1], pwm_frozen}, 9'h005);
		tick(1);
		chk(9'(exec_cnt[0]), 9'h001);
		n = 0;
		while (engine_busy[1] !== 1'b0 && n < 100) begin
			@(posedge mclk);
			n++;
		end
		#1;
		chk({8'h0, prog_wr_allow[1]}, 9'h001);
		host.wr(8'h01, 8'h23);
		#1;
		chk({7'h0, pwm_frozen, pwm_wr_allow}, 9'h001);
		tick(1);
		chk(9'(exec_cnt[0]), 9'h002);
		$display("test load done");
		@(posedge mclk);
		ext_clk_sel <= 1'b0;
		n = 0;
		while (exec_cnt[0] < 3 && n < 3200) begin
			@(posedge mclk);
			n++;
		end
		chk(9'(exec_cnt[0]), 9'h003);
		host.wr(8'h00, 8'h00);
		repeat (2) @(posedge mclk);
		#1;
		chk({7'h0, chip_standby, pwm_wr_allow}, 9'h002);
		$display("test clock done");
		complete_run;
	end
	initial begin
		#200000;
		err_count++;
		complete_run;
	end
endmodule
